/* File: spi_chain_port.sv */
// serial register port of one device in an spi daisy chain
// Notes on behaviour
// - serial access only while select enable high
// - single-device frame is 16 bits, select low
// - frame: command, 7-bit address, data byte
// - sample mosi on rise, change miso on fall
// - old register contents shift out on miso
// - drive miso only while select low
// - write executes when select rises
// - read loads register value into data byte
// - read value appears in dummy's last bits
// - chained read is 32xN bits in two passes
`timescale 1ns/1ps
`include "spi_chain_params.svh"
module spi_chain_port
(
   input  wire logic        mclk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        spi_en_in,
   input  wire logic        sck_in,
   input  wire logic        ss_n_in,
   input  wire logic        mosi_in,
   input  wire logic [7:0]  rd_data_in,
   output logic             miso_out,
   output logic             miso_oe_out,
   output logic             wr_strobe_out,
   output logic [6:0]       wr_addr_out,
   output logic [7:0]       wr_data_out,
   output logic             rd_req_out,
   output logic [6:0]       rd_addr_out,
   output logic             spi_mode_out
);
   spi_chain_pkg::port_state_all_t s_reg;
   spi_chain_pkg::port_state_all_t s_next;

   logic sck_rise;
   logic sck_fall;
   logic ss_fall;
   logic ss_rise;
   logic ss_low;
   logic en;

   ////////////////////////////////////////////////////////////////////////
   // edge detection on synchronised pins
   assign sck_rise = s_reg.pins.sck_sync[1] & ~s_reg.pins.sck_prev;
   assign sck_fall = ~s_reg.pins.sck_sync[1] & s_reg.pins.sck_prev;
   assign ss_fall  = ~s_reg.pins.ssn_sync[1] & s_reg.pins.ssn_prev;
   assign ss_rise  = s_reg.pins.ssn_sync[1] & ~s_reg.pins.ssn_prev;
   assign ss_low   = ~s_reg.pins.ssn_sync[1];
   assign en       = s_reg.pins.en_sync[1];

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      s_next = s_reg;
      s_next.pins.sck_sync  = {s_reg.pins.sck_sync[0], sck_in};
      s_next.pins.ssn_sync  = {s_reg.pins.ssn_sync[0], ss_n_in};
      s_next.pins.mosi_sync = {s_reg.pins.mosi_sync[0], mosi_in};
      s_next.pins.en_sync   = {s_reg.pins.en_sync[0], spi_en_in};
      s_next.pins.sck_prev  = s_reg.pins.sck_sync[1];
      s_next.pins.ssn_prev  = s_reg.pins.ssn_sync[1];
      s_next.req.wr_strobe  = 1'h0;
      s_next.req.rd_req     = 1'h0;
      s_next.rd_load        = 1'h0;
      // read data is taken in the same cycle the request is out
      if (s_reg.rd_load)
      begin
         s_next.shift[`DATA_BITS-1:0] = rd_data_in;
      end
      s_next.miso_oe = en & ss_low;
      if (!en)
      begin
         s_next.state   = spi_chain_pkg::ST_IDLE;
         s_next.miso_oe = 1'h0;
      end
      else
      begin
         case (s_reg.state)
            spi_chain_pkg::ST_IDLE:
            begin
               if (ss_fall)
               begin
                  s_next.state = spi_chain_pkg::ST_FRAME;
                  s_next.miso  = s_reg.shift[`FRAME_BITS-1];
               end
            end
            spi_chain_pkg::ST_FRAME:
            begin
               if (ss_rise)
               begin
                  s_next.state = spi_chain_pkg::ST_IDLE;
                  // frame executes on the select rising edge
                  if (s_reg.shift[`CMD_BIT_POS] == `CMD_WRITE)
                  begin
                     s_next.req.wr_strobe = 1'h1;
                     s_next.req.wr_addr   =
                        s_reg.shift[`ADDR_MSB_POS:`ADDR_LSB_POS];
                     s_next.req.wr_data   =
                        s_reg.shift[`DATA_BITS-1:0];
                  end
                  else
                  begin
                     s_next.req.rd_req  = 1'h1;
                     s_next.req.rd_addr =
                        s_reg.shift[`ADDR_MSB_POS:`ADDR_LSB_POS];
                     s_next.rd_load     = 1'h1;
                  end
               end
               else if (sck_rise)
               begin
                  s_next.shift = {s_reg.shift[`FRAME_BITS-2:0],
                                  s_reg.pins.mosi_sync[1]};
               end
               else if (sck_fall)
               begin
                  s_next.miso = s_reg.shift[`FRAME_BITS-1];
               end
            end
            default:
            begin
               s_next.state = spi_chain_pkg::ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         s_reg       <= '0;
         s_reg.shift <= `SHIFT_RESET;
         s_reg.state <= spi_chain_pkg::ST_IDLE;
         // select idles high: no false select edge after reset
         s_reg.pins.ssn_sync <= `SSN_SYNC_RESET;
         s_reg.pins.ssn_prev <= `SSN_PREV_RESET;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign miso_out      = s_reg.miso;
   assign miso_oe_out   = s_reg.miso_oe;
   assign wr_strobe_out = s_reg.req.wr_strobe;
   assign wr_addr_out   = s_reg.req.wr_addr;
   assign wr_data_out   = s_reg.req.wr_data;
   assign rd_req_out    = s_reg.req.rd_req;
   assign rd_addr_out   = s_reg.req.rd_addr;
   assign spi_mode_out  = s_reg.pins.en_sync[1];

   ////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);

   AST_MODE_OFF_NO_DRIVE: assert property (
      !spi_mode_out |-> ##1 !miso_oe_out)
      else $error("miso driven outside serial mode");
   AST_MISO_OE_SS: assert property (
      (spi_mode_out && ss_low) |=> miso_oe_out)
      else $error("miso not driven while select low");
   AST_MISO_OFF_SS_HIGH: assert property (
      !ss_low |=> !miso_oe_out)
      else $error("miso driven while select high");
   AST_SHIFT_ON_RISE: assert property (
      (s_reg.state == spi_chain_pkg::ST_FRAME && en && sck_rise && !ss_rise)
      |=> s_reg.shift[0] == $past(s_reg.pins.mosi_sync[1]))
      else $error("mosi not shifted on clock rise");
   AST_MISO_ON_FALL: assert property (
      (s_reg.state == spi_chain_pkg::ST_FRAME && en && sck_fall && !ss_rise)
      |=> miso_out == $past(s_reg.shift[15]))
      else $error("miso not updated on clock fall");
   AST_MISO_HOLD: assert property (
      (s_reg.state == spi_chain_pkg::ST_FRAME && !sck_fall && !ss_rise)
      |=> $stable(miso_out))
      else $error("miso changed without clock fall");
   AST_WRITE_EXEC: assert property (
      (s_reg.state == spi_chain_pkg::ST_FRAME && en && ss_rise
       && !s_reg.shift[15])
      |=> wr_strobe_out && wr_data_out == $past(s_reg.shift[7:0])
          && wr_addr_out == $past(s_reg.shift[14:8]))
      else $error("write not executed at select rise");
   AST_READ_LOAD: assert property (
      rd_req_out |=> s_reg.shift[7:0] == $past(rd_data_in)
                     && $stable(s_reg.shift[15:8]))
      else $error("read value not loaded into data byte");
   AST_STROBE_PULSE: assert property (
      wr_strobe_out |=> !wr_strobe_out)
      else $error("write strobe longer than one cycle");
   AST_READ_EXEC: assert property (
      (s_reg.state == spi_chain_pkg::ST_FRAME && en && ss_rise
       && s_reg.shift[`CMD_BIT_POS])
      |=> rd_req_out && !wr_strobe_out
          && rd_addr_out == $past(s_reg.shift[`ADDR_MSB_POS:`ADDR_LSB_POS]))
      else $error("read not requested at select rise");
   AST_READ_PULSE: assert property (
      rd_req_out |=> !rd_req_out)
      else $error("read request longer than one cycle");
   AST_ONE_CMD: assert property (
      !(wr_strobe_out && rd_req_out))
      else $error("write and read issued together");
   AST_PIN_MODE_NO_EXEC: assert property (
      !en |=> !wr_strobe_out && !rd_req_out)
      else $error("command executed in pin mode");
   AST_PIN_MODE_HOLD: assert property (
      (!en && !s_reg.rd_load) |=> $stable(s_reg.shift))
      else $error("shift register changed in pin mode");

   COV_WRITE: cover property (wr_strobe_out);
   COV_READ: cover property (rd_req_out ##[1:1000] ss_fall);
   COV_FRAME: cover property (ss_fall ##[1:1000] ss_rise);
   COV_MODE_OFF: cover property (spi_mode_out ##1 !spi_mode_out);
   COV_PIN_FRAME: cover property (!spi_mode_out && ss_low);
endmodule : spi_chain_port

/* File: spi_chain_params.svh */
// constants of the daisy-chain serial register port
`ifndef SPI_CHAIN_PARAMS_SVH
`define SPI_CHAIN_PARAMS_SVH
`define FRAME_BITS      16
`define ADDR_BITS       7
`define DATA_BITS       8
`define CMD_BIT_POS     15
`define ADDR_MSB_POS    14
`define ADDR_LSB_POS    8
`define CMD_READ        1'h1
`define CMD_WRITE       1'h0
`define SHIFT_RESET     16'h0000
`define SSN_SYNC_RESET  2'h3
`define SSN_PREV_RESET  1'h1
`endif

/* File: spi_chain_pkg.sv */
// types of the daisy-chain serial register port
package spi_chain_pkg;
   typedef struct packed {
      logic [1:0] sck_sync;
      logic [1:0] ssn_sync;
      logic [1:0] mosi_sync;
      logic [1:0] en_sync;
      logic       sck_prev;
      logic       ssn_prev;
   } pin_sync_t;

   typedef struct packed {
      logic       wr_strobe;
      logic [6:0] wr_addr;
      logic [7:0] wr_data;
      logic       rd_req;
      logic [6:0] rd_addr;
   } reg_req_t;

   typedef enum logic {ST_IDLE, ST_FRAME} port_state_t;

   typedef struct packed {
      pin_sync_t   pins;
      port_state_t state;
      logic [15:0] shift;
      logic        miso;
      logic        miso_oe;
      logic        rd_load;
      reg_req_t    req;
   } port_state_all_t;
endpackage : spi_chain_pkg

/* File: spi_host_model.sv */
// host controller model driving the serial register port
`timescale 1ns/1ps
module spi_host_model
(
   output logic      sck_out,
   output logic      ss_n_out,
   output logic      mosi_out,
   input  wire logic miso_in,
   input  wire logic miso_oe_in
);
   logic last;
   // power-up wait shortened to the bench reset
   initial
   begin
      sck_out = 1'b0;
      ss_n_out = 1'b1;
      mosi_out = 1'b1;
      last = 1'b0;
   end
   // n bits msb first, sck idle low outside frames
   task automatic xfer(input int n, input logic [31:0] tx,
                       output logic [31:0] rx);
      rx = '0;
      ss_n_out = 1'b0;
      #200;
      for (int i = n - 1; i >= 0; i--)
      begin
         mosi_out = tx[i];
         #100 sck_out = 1'b1;
         // released line shows the inverse of its last level
         last = (miso_oe_in === 1'b1) ? miso_in : ~last;
         rx[i] = last;
         #100 sck_out = 1'b0;
      end
      #100 ss_n_out = 1'b1;
      #300;
   endtask : xfer
endmodule : spi_host_model

/* File: testbench.sv */
// self-checking bench for the daisy-chain serial register port
`timescale 1ns/1ps
module testbench;
   logic        mclk, rst, en, sck, ss_n, mosi, miso, oe, wstb, rreq, mode;
   logic [7:0]  rd_data, wr_data;
   logic [6:0]  wr_addr, rd_addr;
   logic [15:0] exp_q[$];
   logic [15:0] prev, fr, e;
   logic [31:0] rx;
   int          mismatches, num_checks;
   spi_chain_port u_dut (.mclk_in(mclk), .sys_rst_in(rst), .spi_en_in(en),
      .sck_in(sck), .ss_n_in(ss_n), .mosi_in(mosi), .rd_data_in(rd_data),
      .miso_out(miso), .miso_oe_out(oe), .wr_strobe_out(wstb),
      .wr_addr_out(wr_addr), .wr_data_out(wr_data), .rd_req_out(rreq),
      .rd_addr_out(rd_addr), .spi_mode_out(mode));
   spi_host_model u_host (.sck_out(sck), .ss_n_out(ss_n), .mosi_out(mosi),
      .miso_in(miso), .miso_oe_in(oe));
   task automatic check(input string nm, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic results;
      if (mismatches == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : results
   task automatic send(input logic [15:0] f);
      exp_q.push_back(f);
      u_host.xfer(16, 32'(f), rx);
      check("echo", rx[15:0], prev);
      check("oe idle", oe, 1'b0);
      prev = f;
   endtask : send
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // scoreboard: each executed command takes the oldest note
   always @(posedge mclk)
   begin
      if (wstb === 1'b1 || rreq === 1'b1)
      begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hXXXX;
         if (wstb === 1'b1)
            check("write cmd", {1'b0, wr_addr, wr_data}, e);
         else
            check("read cmd", {1'b1, rd_addr, 8'hFF}, e);
      end
   end
   initial
   begin
      #500000;
      check("timeout", 1'b1, 1'b0);
      results();
   end
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      rst = 1'b1;
      en = 1'b1;
      rd_data = 8'h00;
      void'($urandom(32'h10B43670));
      repeat (3) @(negedge mclk);
      rst = 1'b0;
      repeat (4) @(negedge mclk);
      check("oe reset", oe, 1'b0);
      check("mode", mode, 1'b1);
      prev = 16'h0000;
      for (int k = 0; k < 4; k++)
         send({1'b0, 7'($urandom), 8'($urandom)});
      // read, dummy read, then modified write-back
      for (int k = 0; k < 3; k++)
      begin
         @(negedge mclk);
         rd_data = 8'($urandom);
         fr = {1'b1, 7'($urandom), 8'hFF};
         send(fr);
         exp_q.push_back(16'hFFFF);
         u_host.xfer(16, 32'hFFFF, rx);
         check("read data", rx[15:0], {fr[15:8], rd_data});
         prev = {8'hFF, rd_data};
         send({1'b0, fr[14:8], rd_data ^ 8'h0F});
      end
      // over-long frame: last 16 bits are the command
      fr = {1'b0, 7'($urandom), 8'($urandom)};
      exp_q.push_back(fr);
      u_host.xfer(24, {8'h00, 8'hA5, fr}, rx);
      check("long echo", rx[23:0], {prev, 8'hA5});
      prev = fr;
      // chain length: known value returns after two frames
      rd_data = 8'h5A;
      for (int k = 0; k < 2; k++)
      begin
         exp_q.push_back(16'hFFFF);
         u_host.xfer(16, 32'hFF5A, rx);
      end
      check("chain len", rx[15:0], 16'hFF5A);
      prev = 16'hFF5A;
      // pin mode: frame ignored, shift register untouched
      @(negedge mclk);
      en = 1'b0;
      repeat (4) @(negedge mclk);
      check("mode off", mode, 1'b0);
      u_host.xfer(16, 32'h1234, rx);
      en = 1'b1;
      repeat (4) @(negedge mclk);
      send({1'b0, 7'h55, 8'hAA});
      repeat (10) @(negedge mclk);
      check("pending", exp_q.size(), 0);
      results();
   end
endmodule : testbench
